/* core/dtf_pkg.sv */
package dtf_pkg;
   // Command block addresses (first select low, second high)
   localparam logic [2:0] DTF_A_DATA = 3'h0;
   localparam logic [2:0] DTF_A_ERR_FEAT = 3'h1;
   localparam logic [2:0] DTF_A_COUNT = 3'h2;
   localparam logic [2:0] DTF_A_LOW = 3'h3;
   localparam logic [2:0] DTF_A_MID = 3'h4;
   localparam logic [2:0] DTF_A_HIGH = 3'h5;
   localparam logic [2:0] DTF_A_UNIT = 3'h6;
   localparam logic [2:0] DTF_A_STAT_CMD = 3'h7;
   // Control block address (first select high, second low)
   localparam logic [2:0] DTF_A_CTRL = 3'h6;
   // Error report bits
   localparam int DTF_E_LINK = 7;
   localparam int DTF_E_MEDIA = 6;
   localparam int DTF_E_SECID = 4;
   localparam int DTF_E_REFUSED = 2;
   localparam int DTF_E_SMART = 0;
   localparam logic [7:0] DTF_E_MASK = 8'hd5;
   // Status bits
   localparam int DTF_S_OCC = 7;
   localparam int DTF_S_RDY = 6;
   localparam int DTF_S_WF = 5;
   localparam int DTF_S_SEEK = 4;
   localparam int DTF_S_XFER = 3;
   localparam int DTF_S_FIXED = 2;
   localparam int DTF_S_REV = 1;
   localparam int DTF_S_FAULT = 0;
   // Unit/head bits
   localparam int DTF_U_LBA = 6;
   localparam int DTF_U_UNIT = 4;
   // Device control bits
   localparam int DTF_C_UPPER = 7;
   localparam int DTF_C_SOFT_RESTART_BIT = 2;
   localparam int DTF_C_IDIS = 1;
   // Reset values
   localparam logic [7:0] DTF_REG_RST = 8'h00;
   localparam logic [7:0] DTF_DIAG_OK = 8'h01;
   // Host settle time after occupied clears
   localparam int DTF_SETTLE_NS = 400;
   localparam int DTF_CLK_NS = 10;
   localparam int DTF_SETTLE_CYC = (DTF_SETTLE_NS + DTF_CLK_NS - 1) / DTF_CLK_NS;
   // Sector count meaning of zero
   localparam logic [16:0] DTF_ZERO28 = 17'h00100;
   localparam logic [16:0] DTF_ZERO48 = 17'h10000;
endpackage : dtf_pkg

/* core/dtf_task_file.sv */
`timescale 1ns/1ns
// Function
// - Error report valid on fault; diagnostic after reset
// - Set command_refused on abort or bad code
// - Link check failure set, not multiword DMA
// - Media failure bit 6, sector id bit 4
// - Smart structure bit 0; bits 5,3,1 zero
// - Zero count means 256 or 65536
// - Count zero on success, remainder on failure
// - 28-bit address from low, mid, high
// - 48-bit address uses latest and previous
// - Sector-geometry sector, cylinder low and high
// - Head bits select head, carry address 27-24
// - Unit select bit 4, address mode bit 6
// - Status invalid while occupied, 400 ns settle
// - Status read acknowledges interrupt; copy does not
// - Revolution mark per turn, fixed bit one
// - Freeze seek, fault, ready after error
// - Ready clear from power-on until able
// - Occupied: command block reads return status
// - Command write starts execution
// - Upper view reads previous; writes clear it
// - Interrupt driven only selected and enabled
// - Soft restart bit holds device in reset
// - Chip select decode and shared addresses
// - Two-deep feature, count and address registers
module dtf_task_file
   import dtf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Host parallel bus
   input wire logic cs0_n,
   input wire logic cs1_n,
   input wire logic [2:0] addr,
   input wire logic rd_stb,
   input wire logic wr_stb,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic rdata_oe,
   // Host interrupt pin
   output logic intrq,
   output logic intrq_oe,
   // Strap: this unit's number
   input wire logic unit_id,
   // Command engine side
   output logic cmd_start,
   output logic [7:0] cmd_code,
   output logic [7:0] feature_latest,
   output logic [7:0] feature_prev,
   output logic [47:0] lba48,
   output logic [27:0] lba28,
   output logic [7:0] chs_sector,
   output logic [15:0] chs_cylinder,
   output logic [3:0] head_select_bits,
   output logic lba_mode,
   output logic [16:0] count28,
   output logic [16:0] count48,
   output logic soft_reset_active,
   input wire logic diag_done,
   input wire logic [7:0] diag_code,
   input wire logic engine_ready,
   input wire logic engine_busy,
   input wire logic transfer_request_flag,
   input wire logic seek_done_in,
   input wire logic write_fault_in,
   input wire logic revolution_pulse,
   input wire logic cmd_done,
   input wire logic cmd_fail,
   input wire logic fail_refused,
   input wire logic fail_media,
   input wire logic fail_sector_id,
   input wire logic fail_link,
   input wire logic fail_multiword_dma,
   input wire logic fail_smart,
   input wire logic load_count,
   input wire logic [7:0] remaining_count,
   input wire logic load_head,
   input wire logic [3:0] current_head,
   input wire logic raise_irq
);

   logic cmd_sel, ctl_sel, dev_reset;
   logic rd_status, rd_copy, wr_cmd_block;
   logic [7:0] feat [2], count [2], low [2], mid [2], high [2];
   logic [7:0] unit_head, error_report, drive_control;
   logic fault, irq_pending, rev_mark, frozen;
   logic seek_done_flag, write_fault_flag, unit_ready_flag;
   logic occupied_flag;
   logic [7:0] drive_state;
   logic [7:0] stack_latest [5], stack_prev [5];
   logic [7:0] next_error;

   assign cmd_sel = !cs0_n && cs1_n;
   assign ctl_sel = cs0_n && !cs1_n;
   assign dev_reset = reset || drive_control[DTF_C_SOFT_RESTART_BIT];
   assign soft_reset_active = drive_control[DTF_C_SOFT_RESTART_BIT];
   assign rd_status = rd_stb && cmd_sel && addr == DTF_A_STAT_CMD;
   assign rd_copy = rd_stb && ctl_sel && addr == DTF_A_CTRL;
   // Data port is handled by the transfer path, so it never shifts the stacks
   assign wr_cmd_block = wr_stb && cmd_sel && addr != DTF_A_DATA;

   // Control register survives its own soft reset so the host can release it
   always_ff @(posedge clk) begin
      if (reset) begin
         drive_control <= DTF_REG_RST;
      end else if (wr_stb && ctl_sel && addr == DTF_A_CTRL) begin
         drive_control <= {wdata[7:1], 1'b0};
      end else if (wr_cmd_block) begin
         drive_control[DTF_C_UPPER] <= 1'b0;
      end
   end

   // Two-deep stacks, one per shifting register; entry g answers at address g + 1
   // Latest is always written regardless of upper view
   for (genvar g = 0; g < 5; g++) begin : g_stack
      // Count and low come up holding the diagnostic reset pattern
      localparam logic [7:0] START = (g == 1 || g == 2) ? DTF_DIAG_OK : DTF_REG_RST;
      localparam logic [2:0] SLOT = DTF_A_ERR_FEAT + 3'(g);
      logic push;
      logic [7:0] latest;
      logic [7:0] previous;

      // Writes while occupied are dropped, so a busy engine sees a steady address
      assign push = wr_cmd_block && !occupied_flag && addr == SLOT;

      // Engine rewrite of the count wins over a host write in the same cycle
      always_ff @(posedge clk) begin
         if (dev_reset) begin
            latest <= START;
         end else if (g == 1 && load_count) begin
            latest <= remaining_count;
         end else if (g == 1 && cmd_done && !cmd_fail) begin
            latest <= DTF_REG_RST;
         end else if (push) begin
            latest <= wdata;
         end
      end

      always_ff @(posedge clk) begin
         if (dev_reset) begin
            previous <= DTF_REG_RST;
         end else if (push) begin
            previous <= latest;
         end
      end

      assign stack_latest[g] = latest;
      assign stack_prev[g] = previous;
   end

   // Named views of the stacks for the read mux and the engine
   always_comb begin
      feat = '{stack_latest[0], stack_prev[0]};
      count = '{stack_latest[1], stack_prev[1]};
      low = '{stack_latest[2], stack_prev[2]};
      mid = '{stack_latest[3], stack_prev[3]};
      high = '{stack_latest[4], stack_prev[4]};
   end

   always_ff @(posedge clk) begin
      if (dev_reset) begin
         unit_head <= DTF_REG_RST;
      end else if (load_head) begin
         unit_head[3:0] <= current_head;
      end else if (wr_cmd_block && !occupied_flag && addr == DTF_A_UNIT) begin
         unit_head <= wdata;
      end
   end

   // Command write starts the engine in the next cycle
   always_ff @(posedge clk) begin
      if (dev_reset) begin
         cmd_start <= 1'b0;
      end else begin
         cmd_start <= wr_cmd_block && !occupied_flag && addr == DTF_A_STAT_CMD;
      end
   end

   // Code stays put while occupied, so the engine may read it at any time
   always_ff @(posedge clk) begin
      if (dev_reset) begin
         cmd_code <= DTF_REG_RST;
      end else if (wr_cmd_block && !occupied_flag && addr == DTF_A_STAT_CMD) begin
         cmd_code <= wdata;
      end
   end

   // Failure causes gathered apart from the flop; reserved bits stay low
   always_comb begin
      next_error = DTF_REG_RST;
      next_error[DTF_E_LINK] = fail_link && !fail_multiword_dma;
      next_error[DTF_E_MEDIA] = fail_media;
      next_error[DTF_E_SECID] = fail_sector_id;
      next_error[DTF_E_REFUSED] = fail_refused;
      next_error[DTF_E_SMART] = fail_smart;
   end

   // Error report: diagnostic code after reset, else failure causes
   always_ff @(posedge clk) begin
      if (dev_reset) begin
         error_report <= DTF_REG_RST;
      end else if (diag_done) begin
         error_report <= diag_code;
      end else if (cmd_start) begin
         error_report <= DTF_REG_RST;
      end else if (cmd_done && cmd_fail) begin
         error_report <= next_error;
      end
   end

   // Fault bit tells the host the report is meaningful
   always_ff @(posedge clk) begin
      if (dev_reset) begin
         fault <= 1'b0;
      end else if (diag_done || cmd_start) begin
         fault <= 1'b0;
      end else if (cmd_done && cmd_fail) begin
         fault <= 1'b1;
      end
   end

   // Freeze from error until host reads status; a new error wins over the read
   always_ff @(posedge clk) begin
      if (dev_reset) begin
         frozen <= 1'b0;
      end else if (cmd_done && cmd_fail) begin
         frozen <= 1'b1;
      end else if (rd_status) begin
         frozen <= 1'b0;
      end
   end

   // Seek, fault and ready follow the engine only while not frozen
   always_ff @(posedge clk) begin
      if (dev_reset) begin
         seek_done_flag <= 1'b0;
         write_fault_flag <= 1'b0;
         unit_ready_flag <= 1'b0;
      end else if (!frozen) begin
         seek_done_flag <= seek_done_in;
         write_fault_flag <= write_fault_in;
         unit_ready_flag <= engine_ready;
      end
   end

   // Revolution mark held until the next status read, so it is never missed
   always_ff @(posedge clk) begin
      if (dev_reset) begin
         rev_mark <= 1'b0;
      end else if (revolution_pulse) begin
         rev_mark <= 1'b1;
      end else if (rd_status) begin
         rev_mark <= 1'b0;
      end
   end

   // Pending interrupt: a new request wins over a simultaneous acknowledge
   always_ff @(posedge clk) begin
      if (dev_reset) begin
         irq_pending <= 1'b0;
      end else if (raise_irq) begin
         irq_pending <= 1'b1;
      end else if (rd_status) begin
         irq_pending <= 1'b0;
      end
   end

   // Occupied during reset and from command write until engine idle
   always_ff @(posedge clk) begin
      if (dev_reset) begin
         occupied_flag <= 1'b1;
      end else if (cmd_start) begin
         occupied_flag <= 1'b1;
      end else begin
         occupied_flag <= engine_busy;
      end
   end

   // Status view; alternate copy reads the same bits without side effects
   always_comb begin
      drive_state = DTF_REG_RST;
      drive_state[DTF_S_OCC] = occupied_flag;
      drive_state[DTF_S_RDY] = unit_ready_flag;
      drive_state[DTF_S_WF] = write_fault_flag;
      drive_state[DTF_S_SEEK] = seek_done_flag;
      drive_state[DTF_S_XFER] = transfer_request_flag;
      drive_state[DTF_S_FIXED] = 1'b1;
      drive_state[DTF_S_REV] = rev_mark;
      drive_state[DTF_S_FAULT] = fault;
   end

   // Read data: upper view selects previous entries
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata <= DTF_REG_RST;
      end else if (rd_stb && cmd_sel && occupied_flag) begin
         rdata <= drive_state;
      end else if (rd_stb && cmd_sel) begin
         unique case (addr)
            DTF_A_ERR_FEAT: rdata <= drive_control[DTF_C_UPPER] ? feat[1] :
                                     (error_report & DTF_E_MASK);
            DTF_A_COUNT: rdata <= drive_control[DTF_C_UPPER] ? count[1] : count[0];
            DTF_A_LOW: rdata <= drive_control[DTF_C_UPPER] ? low[1] : low[0];
            DTF_A_MID: rdata <= drive_control[DTF_C_UPPER] ? mid[1] : mid[0];
            DTF_A_HIGH: rdata <= drive_control[DTF_C_UPPER] ? high[1] : high[0];
            DTF_A_UNIT: rdata <= unit_head;
            DTF_A_STAT_CMD: rdata <= drive_state;
            default: rdata <= DTF_REG_RST;
         endcase
      end else if (rd_copy) begin
         rdata <= drive_state;
      end
   end

   // Data lane enable tracks the read strobe; the data port itself is elsewhere
   always_comb begin
      rdata_oe = rd_stb && ((cmd_sel && addr != DTF_A_DATA) || (ctl_sel && addr == DTF_A_CTRL));
   end

   always_comb begin
      intrq = irq_pending;
      intrq_oe = (unit_head[DTF_U_UNIT] == unit_id) && !drive_control[DTF_C_IDIS];
   end

   // Address and count views for the command engine
   always_comb begin
      feature_latest = feat[0];
      feature_prev = feat[1];
      lba28 = {unit_head[3:0], high[0], mid[0], low[0]};
      lba48 = {high[1], mid[1], low[1], high[0], mid[0], low[0]};
      chs_sector = low[0];
      chs_cylinder = {high[0], mid[0]};
      head_select_bits = unit_head[3:0];
      lba_mode = unit_head[DTF_U_LBA];
      count28 = (count[0] == 8'h00) ? DTF_ZERO28 : {9'h000, count[0]};
      count48 = ({count[1], count[0]} == 16'h0000) ? DTF_ZERO48 :
                {1'b0, count[1], count[0]};
   end

endmodule : dtf_task_file

/* bench/dtf_task_file_props.sv */
`timescale 1ns/1ns
module dtf_task_file_props
   import dtf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Watched ports
   input wire logic cs0_n,
   input wire logic cs1_n,
   input wire logic [2:0] addr,
   input wire logic rd_stb,
   input wire logic wr_stb,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rdata_oe,
   input wire logic intrq_oe,
   input wire logic cmd_start,
   input wire logic [7:0] cmd_code,
   input wire logic soft_reset_active,
   input wire logic engine_busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire cb = !cs0_n && cs1_n;
   wire cc = cs0_n && !cs1_n;
   wire cw = wr_stb && cc && addr == DTF_A_CTRL;
   a_start_cause: assert property (cmd_start |-> $past(wr_stb && cb && addr == 3'h7))
      else $error("start without write");
   a_code_latch: assert property (cmd_start |-> cmd_code == $past(wdata))
      else $error("code not latched");
   a_start_pulse: assert property (cmd_start |=> !cmd_start)
      else $error("start too long");
   a_irq_off: assert property (cw && wdata[DTF_C_IDIS] |=> !intrq_oe)
      else $error("irq driven while off");
   a_soft_restart_bit_level: assert property (cw |=> soft_reset_active == $past(wdata[DTF_C_SOFT_RESTART_BIT]))
      else $error("soft reset level");
   a_read_oe: assert property (rdata_oe == (rd_stb && (cb && addr != 3'h0 || cc && addr == 3'h6)))
      else $error("read enable decode");
   a_fixed_one: assert property (rd_stb && (cb && addr == 3'h7 || cc && addr == 3'h6) |=> rdata[2])
      else $error("fixed bit low");
   a_busy_status: assert property (engine_busy ##1 (engine_busy && rd_stb && cb) |=> rdata[7])
      else $error("busy read lacks status");
endmodule : dtf_task_file_props
bind dtf_task_file dtf_task_file_props dtf_task_file_props_i (.*);

/* bench/dtf_host.sv */
`timescale 1ns/1ns
module dtf_host
   import dtf_pkg::*;
(
   // Clock
   input wire logic clk,
   // Parallel bus
   output logic cs0_n,
   output logic cs1_n,
   output logic [2:0] addr,
   output logic rd_stb,
   output logic wr_stb,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   initial {cs0_n, cs1_n, rd_stb, wr_stb, addr, wdata} = 15'h6000;
   task automatic xfer(input logic ctl, input logic w, input logic [2:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(negedge clk);
      {cs0_n, cs1_n} = {ctl, !ctl};
      addr = a;
      wdata = ctl ? d & 8'hfe : d;
      {rd_stb, wr_stb} = {!w, w};
      @(negedge clk);
      q = rdata;
      {cs0_n, cs1_n, rd_stb, wr_stb} = 4'hc;
      // Inverted leftovers, so stale values never pass as fresh
      addr = ~a;
      wdata = ~wdata;
   endtask : xfer
endmodule : dtf_host

/* bench/dtf_task_file_test.sv */
`timescale 1ns/1ns
module dtf_task_file_test;
   import dtf_pkg::*;
   logic clk, reset, cs0_n, cs1_n, rd_stb, wr_stb, rdata_oe, intrq, intrq_oe, unit_id, f;
   logic cmd_start, lba_mode, soft_reset_active, diag_done, engine_ready, engine_busy;
   logic transfer_request_flag, seek_done_in, write_fault_in, revolution_pulse, cmd_done;
   logic cmd_fail, fail_refused, fail_media, fail_sector_id, fail_link, fail_multiword_dma;
   logic fail_smart, load_count, load_head, raise_irq;
   logic [2:0] addr;
   logic [3:0] head_select_bits, current_head;
   logic [7:0] wdata, rdata, cmd_code, feature_latest, feature_prev, chs_sector, diag_code;
   logic [7:0] remaining_count, q;
   logic [15:0] chs_cylinder;
   logic [16:0] count28, count48;
   logic [27:0] lba28;
   logic [47:0] lba48;
   logic [5:0] kinds [7] = '{6'h20, 6'h21, 6'h10, 6'h08, 6'h04, 6'h02, 6'h00};
   int num_errors = 0;
   int cmp_count = 0;
   dtf_task_file dtf_task_file_i (.*);
   dtf_host dtf_host_i (.*);
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic rd(input logic c, input logic [2:0] a);
      dtf_host_i.xfer(c, 1'b0, a, 8'h00, q);
   endtask : rd
   task automatic wr(input logic c, input logic [2:0] a, input logic [7:0] d);
      dtf_host_i.xfer(c, 1'b1, a, d, q);
   endtask : wr
   task automatic t_regs;
      repeat (DTF_SETTLE_CYC) @(negedge clk);
      rd(1'b1, DTF_A_CTRL);
      check(q, 8'h04);
      engine_ready = 1'b1;
      rd(1'b0, DTF_A_STAT_CMD);
      check(q, 8'h44);
      diag_code = DTF_DIAG_OK;
      diag_done = 1'b1;
      @(negedge clk);
      diag_done = 1'b0;
      rd(1'b0, DTF_A_ERR_FEAT);
      check(q, DTF_DIAG_OK & DTF_E_MASK);
      for (int i = 0; i < 2; i++)
         for (int a = 2; a < 6; a++)
            wr(1'b0, 3'(a), a == 2 ? 8'(18 - 18 * i) : 8'(16 * a + i));
      wr(1'b0, DTF_A_UNIT, 8'h4d);
      check(lba48, 48'h504030514131);
      check(lba28, 28'hd514131);
      check({lba_mode, head_select_bits, chs_cylinder, chs_sector}, 29'h1d514131);
      check({count48, count28}, {17'h01200, DTF_ZERO28});
      wr(1'b1, DTF_A_CTRL, 8'h80);
      rd(1'b0, DTF_A_LOW);
      check(q, 8'h30);
      wr(1'b0, DTF_A_COUNT, 8'h00);
      rd(1'b0, DTF_A_LOW);
      check(q, 8'h31);
      check(count48, DTF_ZERO48);
   endtask : t_regs
   task automatic t_cmd(input logic [4:0] k, input logic m);
      f = |k;
      engine_ready = 1'b1;
      {seek_done_in, write_fault_in} = k[1:0];
      {fail_link, fail_media, fail_sector_id, fail_refused, fail_smart} = k;
      fail_multiword_dma = m;
      {remaining_count, current_head} = {3'h0, k, k[3:0]};
      wr(1'b0, DTF_A_STAT_CMD, 8'h20 + k);
      check(cmd_code, 8'h20 + k);
      engine_busy = 1'b1;
      rd(1'b0, DTF_A_LOW);
      check(q[7], 1'b1);
      engine_busy = 1'b0;
      {cmd_done, cmd_fail, load_count, load_head, raise_irq} = {1'b1, f, f, 2'b11};
      @(negedge clk);
      {cmd_done, cmd_fail, load_count, load_head, raise_irq} = 5'h00;
      {engine_ready, seek_done_in, write_fault_in} = {1'b0, ~k[1:0]};
      repeat (DTF_SETTLE_CYC) @(negedge clk);
      rd(1'b1, DTF_A_CTRL);
      check({intrq, q}, {2'b10, f, f ? k[0] : !k[0], f ? k[1] : !k[1], 3'h2, f});
      rd(1'b0, DTF_A_ERR_FEAT);
      check(q, {k[4] & !m, k[3], 1'b0, k[2], 1'b0, k[1], 1'b0, k[0]});
      rd(1'b0, DTF_A_COUNT);
      check({q, head_select_bits}, {3'h0, k, k[3:0]});
      rd(1'b0, DTF_A_STAT_CMD);
      check(intrq, 1'b0);
      rd(1'b0, DTF_A_STAT_CMD);
      check(q, {2'b00, ~k[0], ~k[1], 3'h2, f});
   endtask : t_cmd
   task automatic t_ctrl;
      wr(1'b1, DTF_A_CTRL, 8'h02);
      check(intrq_oe, 1'b0);
      wr(1'b1, DTF_A_CTRL, 8'h00);
      check(intrq_oe, 1'b1);
      wr(1'b0, DTF_A_UNIT, 8'h10);
      check(intrq_oe, 1'b0);
      wr(1'b1, DTF_A_CTRL, 8'h05);
      check(soft_reset_active, 1'b1);
      wr(1'b1, DTF_A_CTRL, 8'h00);
      repeat (DTF_SETTLE_CYC) @(negedge clk);
      rd(1'b0, DTF_A_UNIT);
      check({soft_reset_active, q}, 9'h000);
      revolution_pulse = 1'b1;
      @(negedge clk);
      revolution_pulse = 1'b0;
      rd(1'b1, DTF_A_CTRL);
      check(q[1], 1'b1);
      rd(1'b0, DTF_A_STAT_CMD);
      rd(1'b0, DTF_A_STAT_CMD);
      check(q[1], 1'b0);
      rd(1'b1, 3'h0);
   endtask : t_ctrl
   task automatic print_verdict;
      if (num_errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      reset = 1'b1;
      {unit_id, diag_done, diag_code, transfer_request_flag, engine_ready, engine_busy} = '0;
      {seek_done_in, write_fault_in, revolution_pulse, cmd_done, cmd_fail, load_count} = '0;
      {fail_refused, fail_media, fail_sector_id, fail_link, fail_multiword_dma, fail_smart} = '0;
      {remaining_count, load_head, current_head, raise_irq} = '0;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      t_regs;
      foreach (kinds[i])
         t_cmd(kinds[i][5:1], kinds[i][0]);
      t_ctrl;
      print_verdict;
   end
   // Ceiling far above the few hundred cycles the run needs
   initial begin
      repeat (4000) @(posedge clk);
      num_errors++;
      print_verdict;
   end
endmodule : dtf_task_file_test
